// ---- logic/emac_pkg.sv ----
// Shared constants of the Ethernet controller slice: register offsets, field positions and reset values.
// Assumes a byte-addressed register port with 32-bit words at aligned offsets.
package emac_pkg;
    // Register byte offsets.
    localparam logic [7:0] EMAC_OFF_CTRL = 8'h00; // Enable and accept-all control.
    localparam logic [7:0] EMAC_OFF_RAW = 8'h04; // Raw interrupt status, write one to clear sources 0 to 5.
    localparam logic [7:0] EMAC_OFF_MASK = 8'h08; // Interrupt enable mask.
    localparam logic [7:0] EMAC_OFF_MASKED = 8'h0c; // Masked interrupt status, read only.
    localparam logic [7:0] EMAC_OFF_ADDR_LO = 8'h10; // Station address octets 0 to 3.
    localparam logic [7:0] EMAC_OFF_ADDR_HI = 8'h14; // Station address octets 4 and 5.
    localparam logic [7:0] EMAC_OFF_PKTCNT = 8'h18; // Complete packets waiting in the receive FIFO.
    // Control register fields.
    localparam int EMAC_CTRL_ENABLE_BIT = 0; // Controller enable.
    localparam int EMAC_CTRL_ACCEPT_ALL_BIT = 1; // Accept all frames.
    // Interrupt source positions.
    localparam int EMAC_NUM_IRQ = 7; // Number of interrupt sources.
    localparam int EMAC_IRQ_XCVR = 0; // Transceiver event.
    localparam int EMAC_IRQ_MGMT = 1; // Management transaction done.
    localparam int EMAC_IRQ_RXERR = 2; // Receive error.
    localparam int EMAC_IRQ_RXOF = 3; // Receive overflow.
    localparam int EMAC_IRQ_TXDONE = 4; // Transmit done.
    localparam int EMAC_IRQ_TXERR = 5; // Transmit error.
    localparam int EMAC_IRQ_RXPEND = 6; // Receive packet pending.
    // Station address layout.
    localparam int EMAC_ADDR_OCTETS = 6; // Octets in the station address.
    localparam int EMAC_ADDR_BITS = 48; // Bits in the station address.
    // Reset values.
    localparam logic [47:0] EMAC_ADDR_RESET = 48'h0; // Station address after reset.
    localparam logic [6:0] EMAC_MASK_RESET = 7'h00; // All sources disabled after reset.
endpackage : emac_pkg

// ---- logic/emac_addr_unit.sv ----
// Station address unit: destination filter on received octets and LSB-first serialiser for sending the address.
// Assumes the receive octet stream and the send request come from logic on the same clock.
`timescale 1ns/1ps
module emac_addr_unit
    import emac_pkg::*;
(
    input wire logic clk_i, // System clock.
    input wire logic resetn_i, // Asynchronous reset, active low.
    input wire logic [47:0] station_addr_i, // Octet k sits in bits 8k+7..8k, octet 0 leftmost.
    input wire logic accept_all_i, // Accept every frame when high.
    input wire logic rx_sof_i, // First destination octet of a frame, with valid.
    input wire logic [7:0] rx_octet_i, // Received octet.
    input wire logic rx_octet_valid_i, // Received octet is valid.
    input wire logic tx_addr_go_i, // Start sending the station address.
    output logic match_valid_o, // One-cycle pulse when the filter has decided.
    output logic match_accept_o, // Decision: frame accepted.
    output logic tx_bit_o, // Serial address bit.
    output logic tx_bit_valid_o // Serial address bit is valid.
);
    logic [2:0] rx_idx_reg; // Index of the next destination octet.
    logic rx_eq_reg; // All octets so far matched.
    logic rx_busy_reg; // Collecting destination octets.
    logic [5:0] tx_idx_reg; // Bit index being sent.
    logic tx_busy_reg; // Serialiser running.
    logic [2:0] cur_idx; // Octet index of the current receive octet.
    logic cur_eq; // Current octet matches its station address octet.
    logic prior_eq; // Match state carried into the current octet.

    // Octet index and match carry for the current receive octet.
    always_comb begin
        cur_idx = rx_sof_i ? 3'h0 : rx_idx_reg;
        prior_eq = rx_sof_i ? 1'b1 : rx_eq_reg;
        cur_eq = (rx_octet_i == station_addr_i[8 * cur_idx +: 8]);
    end

    // Destination compare over the first six octets, octet 0 first.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_idx_reg <= 3'h0;
            rx_eq_reg <= 1'b0;
            rx_busy_reg <= 1'b0;
            match_valid_o <= 1'b0;
            match_accept_o <= 1'b0;
        end else begin
            match_valid_o <= 1'b0;
            if (rx_octet_valid_i && (rx_sof_i || rx_busy_reg)) begin
                rx_eq_reg <= prior_eq && cur_eq;
                if (cur_idx == 3'(EMAC_ADDR_OCTETS - 1)) begin
                    // Last address octet decides; accept-all overrides the compare.
                    rx_busy_reg <= 1'b0;
                    rx_idx_reg <= 3'h0;
                    match_valid_o <= 1'b1;
                    match_accept_o <= accept_all_i || (prior_eq && cur_eq);
                end else begin
                    rx_busy_reg <= 1'b1;
                    rx_idx_reg <= cur_idx + 3'h1;
                end
            end
        end
    end

    // Serialiser: octet 0 first, each octet least significant bit first.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_idx_reg <= 6'h00;
            tx_busy_reg <= 1'b0;
            tx_bit_o <= 1'b0;
            tx_bit_valid_o <= 1'b0;
        end else if (tx_busy_reg || tx_addr_go_i) begin
            // Index 8k+b is octet k bit b, so a rising index gives the wire order.
            tx_bit_o <= station_addr_i[tx_busy_reg ? tx_idx_reg : 6'h00];
            tx_bit_valid_o <= 1'b1;
            if ((tx_busy_reg ? tx_idx_reg : 6'h00) == 6'(EMAC_ADDR_BITS - 1)) begin
                tx_busy_reg <= 1'b0;
                tx_idx_reg <= 6'h00;
            end else begin
                tx_busy_reg <= 1'b1;
                tx_idx_reg <= (tx_busy_reg ? tx_idx_reg : 6'h00) + 6'h01;
            end
        end else begin
            tx_bit_valid_o <= 1'b0;
        end
    end
endmodule : emac_addr_unit

// ---- logic/emac_ctrl.sv ----
// Ethernet controller slice: enable, interrupt sources, station address registers and filter.
// Assumes event strobes come from MAC logic on clk_i; the transceiver interrupt is an asynchronous pin.
//
// What this block does
// - Enable starts transmitter, receiver, empties receive FIFO.
// - Clear mask clears chosen sources, others kept.
// - Only enabled sources reach the interrupt line.
// - Raw and masked status both readable.
// - Transceiver interrupt sets transceiver event flag.
// - Management transaction done sets its flag.
// - Receive failure sets receive error flag.
// - Oversized incoming frame sets overflow flag.
// - Sent transmit packet sets transmit done.
// - Retry exhaustion or bad length sets error.
// - Pending flag high while complete packets wait.
// - Without accept-all, filter on station address.
// - Six-octet host-writable station address stored.
// - Address reads back in written order.
// - Address sent leftmost octet first, LSB first.
// - Disable stops both directions, flushes receive FIFO.
// - Accept-all setting receives every frame.
// - Packet count: up on FCS, down on read.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module emac_ctrl
    import emac_pkg::*;
#(
    parameter int PKT_CNT_W = 6 // Width of the receive packet counter.
) (
    input wire logic clk_i, // System clock, 40 MHz.
    input wire logic resetn_i, // Asynchronous reset, active low.
    input wire logic [7:0] addr_i, // Register byte address.
    input wire logic [31:0] wdata_i, // Register write data.
    input wire logic wr_i, // Write strobe.
    input wire logic rd_i, // Read strobe.
    output logic [31:0] rdata_o, // Read data, valid the cycle after the read strobe.
    input wire logic xcvr_irq_i, // Transceiver interrupt pin, active high, asynchronous.
    input wire logic mgmt_done_i, // Management transaction completed successfully.
    input wire logic rx_err_i, // Reception failed: length, check sequence or transceiver error.
    input wire logic rx_overflow_i, // Incoming frame larger than free receive FIFO space.
    input wire logic tx_done_i, // Transmit packet sent successfully.
    input wire logic tx_err_i, // Transmit failed: retries exhausted or bad length word.
    input wire logic rx_frame_done_i, // Check sequence of a frame received into the FIFO.
    input wire logic rx_pkt_read_i, // Host finished reading one packet from the FIFO.
    input wire logic rx_sof_i, // First destination octet of an incoming frame.
    input wire logic [7:0] rx_octet_i, // Incoming octet.
    input wire logic rx_octet_valid_i, // Incoming octet valid.
    input wire logic tx_addr_go_i, // Request to send the station address on the wire.
    output logic tx_enable_o, // Transmitter enabled.
    output logic rx_enable_o, // Receiver enabled.
    output logic rx_fifo_flush_o, // One-cycle pulse that empties the receive FIFO.
    output logic irq_o, // Processor interrupt, active high.
    output logic match_valid_o, // Filter decision pulse.
    output logic match_accept_o, // Filter decision: accept frame.
    output logic tx_bit_o, // Serial station address bit.
    output logic tx_bit_valid_o // Serial station address bit valid.
);
    logic enable_reg; // Controller enable bit.
    logic accept_all_reg; // Accept-all reception setting.
    logic [5:0] sticky_reg; // Sticky raw sources 0 to 5.
    logic [6:0] mask_reg; // Interrupt enable mask.
    logic [47:0] station_addr_reg; // Station address, octet k in bits 8k+7..8k.
    logic [PKT_CNT_W-1:0] pkt_cnt_reg; // Complete packets in the receive FIFO.
    logic xcvr_sync1_reg; // First synchroniser stage of the transceiver pin.
    logic xcvr_sync2_reg; // Second synchroniser stage.
    logic xcvr_prev_reg; // Previous synchronised level for edge detection.
    logic [6:0] raw_status; // Raw interrupt status as seen by software.
    logic [5:0] set_events; // Events that set sticky sources this cycle.
    logic [5:0] clear_sel; // Sources selected by a clear write this cycle.
    logic [31:0] rdata_next; // Read data for the next cycle.
    logic wr_ctrl; // Write to the control register.
    logic enable_change; // Enable bit is being changed.

    // Transceiver pin synchroniser; only the second stage feeds logic.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            xcvr_sync1_reg <= 1'b0;
            xcvr_sync2_reg <= 1'b0;
            xcvr_prev_reg <= 1'b0;
        end else begin
            xcvr_sync1_reg <= xcvr_irq_i;
            xcvr_sync2_reg <= xcvr_sync1_reg;
            xcvr_prev_reg <= xcvr_sync2_reg;
        end
    end

    // Control writes and the enable change detection.
    always_comb begin
        wr_ctrl = wr_i && (addr_i == EMAC_OFF_CTRL);
        enable_change = wr_ctrl && (wdata_i[EMAC_CTRL_ENABLE_BIT] != enable_reg);
    end

    // Control register: enable and accept-all.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_reg <= 1'b0;
            accept_all_reg <= 1'b0;
        end else if (wr_ctrl) begin
            enable_reg <= wdata_i[EMAC_CTRL_ENABLE_BIT];
            accept_all_reg <= wdata_i[EMAC_CTRL_ACCEPT_ALL_BIT];
        end
    end

    // Transmitter and receiver follow enable; any change of enable empties the receive FIFO.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_enable_o <= 1'b0;
            rx_enable_o <= 1'b0;
            rx_fifo_flush_o <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                tx_enable_o <= wdata_i[EMAC_CTRL_ENABLE_BIT];
                rx_enable_o <= wdata_i[EMAC_CTRL_ENABLE_BIT];
            end
            rx_fifo_flush_o <= enable_change;
        end
    end

    // Packet count: flush wins, simultaneous up and down cancel.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pkt_cnt_reg <= '0;
        end else if (enable_change) begin
            // The FIFO is emptied on enable and on disable, so no packet survives.
            pkt_cnt_reg <= '0;
        end else if (rx_frame_done_i && rx_enable_o && !rx_pkt_read_i) begin
            // Saturate rather than wrap; a wrap would lose the pending indication.
            if (pkt_cnt_reg != {PKT_CNT_W{1'b1}}) begin
                pkt_cnt_reg <= pkt_cnt_reg + PKT_CNT_W'(1);
            end
        end else if (rx_pkt_read_i && !(rx_frame_done_i && rx_enable_o)) begin
            if (pkt_cnt_reg != '0) begin
                pkt_cnt_reg <= pkt_cnt_reg - PKT_CNT_W'(1);
            end
        end
    end

    // Source events and clear selection.
    always_comb begin
        set_events = '0;
        set_events[EMAC_IRQ_XCVR] = xcvr_sync2_reg && !xcvr_prev_reg;
        set_events[EMAC_IRQ_MGMT] = mgmt_done_i;
        set_events[EMAC_IRQ_RXERR] = rx_err_i;
        set_events[EMAC_IRQ_RXOF] = rx_overflow_i;
        set_events[EMAC_IRQ_TXDONE] = tx_done_i;
        set_events[EMAC_IRQ_TXERR] = tx_err_i;
        clear_sel = (wr_i && (addr_i == EMAC_OFF_RAW)) ? wdata_i[5:0] : 6'h00;
    end

    // Sticky sources: a set in the same cycle as its clear wins.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sticky_reg <= 6'h00;
        end else begin
            sticky_reg <= (sticky_reg & ~clear_sel) | set_events;
        end
    end

    // Raw view: the pending source is live from the packet count.
    always_comb begin
        raw_status = {pkt_cnt_reg != '0, sticky_reg};
    end

    // Interrupt enable mask.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_reg <= EMAC_MASK_RESET;
        end else if (wr_i && (addr_i == EMAC_OFF_MASK)) begin
            mask_reg <= wdata_i[EMAC_NUM_IRQ-1:0];
        end
    end

    // Processor interrupt: only enabled sources count.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(raw_status & mask_reg);
        end
    end

    // Station address: octet 0 in the low byte of the low word.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            station_addr_reg <= EMAC_ADDR_RESET;
        end else if (wr_i && (addr_i == EMAC_OFF_ADDR_LO)) begin
            station_addr_reg[31:0] <= wdata_i;
        end else if (wr_i && (addr_i == EMAC_OFF_ADDR_HI)) begin
            station_addr_reg[47:32] <= wdata_i[15:0];
        end
    end

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (addr_i)
            EMAC_OFF_CTRL: begin
                rdata_next[EMAC_CTRL_ENABLE_BIT] = enable_reg;
                rdata_next[EMAC_CTRL_ACCEPT_ALL_BIT] = accept_all_reg;
            end
            EMAC_OFF_RAW: begin
                rdata_next[EMAC_NUM_IRQ-1:0] = raw_status;
            end
            EMAC_OFF_MASK: begin
                rdata_next[EMAC_NUM_IRQ-1:0] = mask_reg;
            end
            EMAC_OFF_MASKED: begin
                rdata_next[EMAC_NUM_IRQ-1:0] = raw_status & mask_reg;
            end
            EMAC_OFF_ADDR_LO: begin
                rdata_next = station_addr_reg[31:0];
            end
            EMAC_OFF_ADDR_HI: begin
                rdata_next[15:0] = station_addr_reg[47:32];
            end
            EMAC_OFF_PKTCNT: begin
                rdata_next[PKT_CNT_W-1:0] = pkt_cnt_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rd_i ? rdata_next : 32'h0000_0000;
        end
    end

    // Destination filter and address serialiser.
    emac_addr_unit u_addr (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .station_addr_i(station_addr_reg),
        .accept_all_i(accept_all_reg),
        .rx_sof_i(rx_sof_i && rx_enable_o),
        .rx_octet_i(rx_octet_i),
        .rx_octet_valid_i(rx_octet_valid_i && rx_enable_o),
        .tx_addr_go_i(tx_addr_go_i && tx_enable_o),
        .match_valid_o(match_valid_o),
        .match_accept_o(match_accept_o),
        .tx_bit_o(tx_bit_o),
        .tx_bit_valid_o(tx_bit_valid_o)
    );
endmodule : emac_ctrl

// ---- bench/emac_ctrl_asserts.sv ----
// Checker for the controller slice: enables, flush, read port, interrupt, filter and serial address.
// Assumes one clock domain with the asynchronous active-low reset of the design.
`timescale 1ns/1ps
module emac_ctrl_chk
    import emac_pkg::*;
#(
    parameter int PKT_CNT_W = 6 // Packet counter width.
) (
    input wire logic clk_i, // Clock.
    input wire logic resetn_i, // Reset, active low.
    input wire logic [7:0] addr_i, // Register address.
    input wire logic rd_i, // Read strobe.
    input wire logic [31:0] rdata_o, // Read data.
    input wire logic tx_addr_go_i, // Address send request.
    input wire logic rx_octet_valid_i, // Octet valid.
    input wire logic tx_enable_o, // Transmitter on.
    input wire logic rx_enable_o, // Receiver on.
    input wire logic rx_fifo_flush_o, // Flush pulse.
    input wire logic irq_o, // Interrupt.
    input wire logic match_valid_o, // Filter decision.
    input wire logic tx_bit_valid_o // Serial bit valid.
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic [6:0] run_cnt; // Length of the current serial burst.

    // Counts consecutive valid serial bits so the burst length can be judged.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_cnt <= 7'h00;
        end else if (tx_bit_valid_o) begin
            run_cnt <= run_cnt + 7'h01;
        end else begin
            run_cnt <= 7'h00;
        end
    end

    a_both_directions: assert property (tx_enable_o == rx_enable_o)
        else $error("Transmit and receive enables differ.");
    a_flush_on_change: assert property ($changed(tx_enable_o) |-> rx_fifo_flush_o)
        else $error("Enable changed without a receive flush.");
    a_flush_cause: assert property (rx_fifo_flush_o |-> $changed(tx_enable_o))
        else $error("Receive flush without an enable change.");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("Read data not zero outside a read answer.");
    a_masked_irq: assert property (rd_i && addr_i == EMAC_OFF_MASKED |=> irq_o == (|rdata_o[6:0]))
        else $error("Interrupt line disagrees with masked status.");
    a_ctrl_readback: assert property (rd_i && addr_i == EMAC_OFF_CTRL |=> rdata_o[0] == tx_enable_o)
        else $error("Control read disagrees with enable output.");
    a_match_cause: assert property (match_valid_o |-> $past(rx_octet_valid_i) && $past(rx_enable_o))
        else $error("Filter decision without a received octet.");
    a_match_pulse: assert property (match_valid_o |=> !match_valid_o)
        else $error("Filter decision longer than one cycle.");
    a_serial_start: assert property ($rose(tx_bit_valid_o) |-> $past(tx_addr_go_i) && tx_enable_o)
        else $error("Serial address started without a request.");
    a_serial_length: assert property ($fell(tx_bit_valid_o) |-> run_cnt == 7'h30)
        else $error("Serial address burst not 48 bits long.");

    c_flush: cover property (rx_fifo_flush_o);
    c_irq: cover property (irq_o);
    c_match: cover property (match_valid_o);
    c_serial: cover property ($fell(tx_bit_valid_o));
endmodule : emac_ctrl_chk

bind emac_ctrl emac_ctrl_chk #(.PKT_CNT_W(PKT_CNT_W)) u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .tx_addr_go_i(tx_addr_go_i), .rx_octet_valid_i(rx_octet_valid_i), .tx_enable_o(tx_enable_o),
    .rx_enable_o(rx_enable_o), .rx_fifo_flush_o(rx_fifo_flush_o), .irq_o(irq_o),
    .match_valid_o(match_valid_o), .tx_bit_valid_o(tx_bit_valid_o)
);

// ---- bench/emac_phy_model.sv ----
// Transceiver model: drives the interrupt pin and the received destination octets.
// Assumes the bench calls its tasks and that it shares the system clock.
`timescale 1ns/1ps
module emac_phy_model (
    input wire logic clk_i, // System clock.
    output logic xcvr_irq_o, // Interrupt pin, active high.
    output logic rx_sof_o, // First destination octet.
    output logic [7:0] rx_octet_o, // Received octet.
    output logic rx_octet_valid_o // Octet valid.
);
    // Quiet lines at time zero.
    initial begin
        xcvr_irq_o = 1'b0;
        rx_sof_o = 1'b0;
        rx_octet_o = 8'h00;
        rx_octet_valid_o = 1'b0;
    end

    // Holds the interrupt pin high for a few cycles, as a transceiver event does.
    task automatic raise_irq();
        @(posedge clk_i);
        xcvr_irq_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        xcvr_irq_o <= 1'b0;
    endtask : raise_irq

    // Sends six octets leftmost first; the idle bus then shows the inverse of the last octet.
    task automatic send_dest(input logic [47:0] dest);
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i);
            rx_sof_o <= (k == 0);
            rx_octet_o <= dest[8*k +: 8];
            rx_octet_valid_o <= 1'b1;
        end
        @(posedge clk_i);
        rx_sof_o <= 1'b0;
        rx_octet_valid_o <= 1'b0;
        rx_octet_o <= ~dest[47:40];
    endtask : send_dest
endmodule : emac_phy_model

// ---- bench/tb_top.sv ----
// Testbench for the controller slice: register tasks, event pulses, filter and serial address.
// Assumes the design, its checker and the transceiver model are compiled before it.
`timescale 1ns/1ps
module tb_top
    import emac_pkg::*;
;
    localparam logic [47:0] STATION = 48'h0bf06e19c235; // Octet 0 is 8'h35.
    localparam logic [47:0] OTHER = STATION ^ 48'h010000000000; // Differs in the last octet.
    logic clk_i = 1'b0; // System clock.
    logic resetn_i = 1'b0; // Reset, active low.
    logic [7:0] addr_i = 8'h00; // Register address.
    logic [31:0] wdata_i = 32'h0; // Write data.
    logic wr_i = 1'b0; // Write strobe.
    logic rd_i = 1'b0; // Read strobe.
    logic [8:1] ev = 8'h00; // Event pulses, bit n as listed at the instance.
    logic [31:0] rdata_o; // Read data.
    logic xcvr_irq, sof, oct_valid, tx_en, rx_en, flush, irq_o, m_valid, m_accept, s_bit, s_valid; // Lines.
    logic [7:0] octet; // Received octet.
    int failures = 0; // Mismatches seen.
    int compares = 0; // Comparisons made.

    // The clock toggles every half period of 12.5 ns.
    always #12.5 clk_i = ~clk_i;

    emac_ctrl #(.PKT_CNT_W(6)) uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .xcvr_irq_i(xcvr_irq), .mgmt_done_i(ev[1]), .rx_err_i(ev[2]),
        .rx_overflow_i(ev[3]), .tx_done_i(ev[4]), .tx_err_i(ev[5]), .rx_frame_done_i(ev[6]),
        .rx_pkt_read_i(ev[7]), .rx_sof_i(sof), .rx_octet_i(octet), .rx_octet_valid_i(oct_valid),
        .tx_addr_go_i(ev[8]), .tx_enable_o(tx_en), .rx_enable_o(rx_en), .rx_fifo_flush_o(flush),
        .irq_o(irq_o), .match_valid_o(m_valid), .match_accept_o(m_accept), .tx_bit_o(s_bit),
        .tx_bit_valid_o(s_valid)
    );
    emac_phy_model u_phy (
        .clk_i(clk_i), .xcvr_irq_o(xcvr_irq), .rx_sof_o(sof), .rx_octet_o(octet), .rx_octet_valid_o(oct_valid)
    );

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One-cycle register write.
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : bus_write

    // One-cycle register read; the answer stands in the following cycle only.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask : rd_chk

    // One-cycle pulse on an event input.
    task automatic pulse(input int i);
        @(posedge clk_i);
        ev[i] <= 1'b1;
        @(posedge clk_i);
        ev[i] <= 1'b0;
    endtask : pulse

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 8; i++) rd_chk(8'(4 * i), 32'h0);
        bus_write(EMAC_OFF_ADDR_LO, STATION[31:0]);
        bus_write(EMAC_OFF_ADDR_HI, {16'h0, STATION[47:32]});
        rd_chk(EMAC_OFF_ADDR_LO, STATION[31:0]);
        rd_chk(EMAC_OFF_ADDR_HI, {16'h0, STATION[47:32]});
        bus_write(EMAC_OFF_MASKED, 32'h7f);
        rd_chk(EMAC_OFF_MASKED, 32'h0);
        bus_write(EMAC_OFF_CTRL, 32'h1);
        #1;
        check({29'h0, flush, rx_en, tx_en}, 32'h7);
        for (int i = 1; i < 6; i++) begin
            pulse(i);
            rd_chk(EMAC_OFF_RAW, (32'h1 << (i + 1)) - 32'h2);
        end
        bus_write(EMAC_OFF_MASK, 32'h14);
        rd_chk(EMAC_OFF_MASKED, 32'h14);
        check({31'h0, irq_o}, 32'h1);
        // The handler clears its sources first, before any further status work.
        bus_write(EMAC_OFF_RAW, 32'h14);
        rd_chk(EMAC_OFF_RAW, 32'h2a);
        rd_chk(EMAC_OFF_MASKED, 32'h0);
        check({31'h0, irq_o}, 32'h0);
        // An event and a clear of the same source at one edge: the event wins.
        fork
            pulse(4);
            bus_write(EMAC_OFF_RAW, 32'h10);
        join
        rd_chk(EMAC_OFF_RAW, 32'h3a);
        bus_write(EMAC_OFF_RAW, 32'h3f);
        u_phy.raise_irq();
        rd_chk(EMAC_OFF_RAW, 32'h1);
        bus_write(EMAC_OFF_RAW, 32'h1);
        pulse(6);
        pulse(6);
        rd_chk(EMAC_OFF_PKTCNT, 32'h2);
        bus_write(EMAC_OFF_RAW, 32'h40);
        rd_chk(EMAC_OFF_RAW, 32'h40);
        pulse(7);
        pulse(7);
        rd_chk(EMAC_OFF_RAW, 32'h0);
        u_phy.send_dest(STATION);
        #1;
        check({30'h0, m_valid, m_accept}, 32'h3);
        u_phy.send_dest(OTHER);
        #1;
        check({30'h0, m_valid, m_accept}, 32'h2);
        bus_write(EMAC_OFF_CTRL, 32'h3);
        u_phy.send_dest(OTHER);
        #1;
        check({30'h0, m_valid, m_accept}, 32'h3);
        pulse(8);
        for (int i = 0; i < 48; i++) begin
            #1;
            check({30'h0, s_valid, s_bit}, {30'h0, 1'b1, STATION[i]});
            @(posedge clk_i);
        end
        #1;
        check({31'h0, s_valid}, 32'h0);
        pulse(6);
        bus_write(EMAC_OFF_CTRL, 32'h2);
        #1;
        check({29'h0, flush, rx_en, tx_en}, 32'h4);
        rd_chk(EMAC_OFF_PKTCNT, 32'h0);
        pulse(6);
        rd_chk(EMAC_OFF_PKTCNT, 32'h0);
        // Address change: stay disabled, reprogram the address, then enable again.
        bus_write(EMAC_OFF_ADDR_HI, {16'h0, OTHER[47:32]});
        bus_write(EMAC_OFF_CTRL, 32'h1);
        #1;
        check({29'h0, flush, rx_en, tx_en}, 32'h7);
        rd_chk(EMAC_OFF_CTRL, 32'h1);
        u_phy.send_dest(OTHER);
        #1;
        check({30'h0, m_valid, m_accept}, 32'h3);
        tally_and_finish();
    end
endmodule : tb_top
